// ===== fesp_seq.v
`timescale 1ns/1ps
`default_nettype none
`include "fesp_regs.vh"

module fesp_seq #(
    parameter WHOLE_ERASE_CYC = `FESP_WHOLE_ERASE_CYC,
    parameter BLOCK_ERASE_CYC = `FESP_BLOCK_ERASE_CYC,
    parameter SECTOR_ERASE_CYC = `FESP_SECTOR_ERASE_CYC,
    parameter PROG_CYC = `FESP_PROG_CYC,
    parameter [7:0] MAKER_CODE = 8'hA5, // arbitrary value
    parameter [7:0] PART_CODE = 8'h3C // arbitrary value
) (
    // clock and reset
    input wire clock,
    input wire rst_b,
    input wire clk_en,
    // serial pins
    input wire spi_cs_b,
    input wire spi_sclk,
    input wire spi_mosi,
    output reg spi_miso,
    output reg spi_miso_oe_b,
    // configuration
    input wire addr4_mode,
    input wire protect_complement,
    input wire block_protect_bit3,
    input wire block_protect_bit2,
    input wire block_protect_bit1,
    input wire block_protect_bit0,
    input wire lock_any,
    // status
    output reg busy,
    output reg write_enable_latch,
    output reg paused_flag,
    output reg power_down,
    // array operation
    output reg op_start,
    output reg [7:0] op_code,
    output reg [31:0] op_addr,
    output reg array_fill_ones,
    output reg cmd_refused
);

    // class of the operation held in the main timer
    localparam [1:0] CLS_PROG = 2'h0;
    localparam [1:0] CLS_ERASE = 2'h1;
    localparam [1:0] CLS_CHIP = 2'h2;

    // power states
    localparam [1:0] PS_AWAKE = 2'h0;
    localparam [1:0] PS_ENTERING = 2'h1;
    localparam [1:0] PS_ASLEEP = 2'h2;
    localparam [1:0] PS_WAKING = 2'h3;

    reg [1:0] rst_pipe;
    reg [2:0] pin_meta;
    reg [2:0] pin_sync;
    reg sclk_prev;
    reg cs_prev;
    reg [11:0] bit_cnt;
    reg [7:0] opcode;
    reg [31:0] addr;
    reg [3:0] out_idx;
    reg [1:0] main_cls;
    reg [1:0] pstate;

    wire rst_sys_b;
    wire main_run;
    wire main_done;
    wire side_done;
    wire halt_done;
    wire pwr_done;

    // reset release through two flops, assertion stays asynchronous
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sys_b = rst_pipe[1];

    // pin synchronisers; only the second stage and its delayed copy are looked at
    always @(posedge clock or negedge rst_sys_b) begin
        if (!rst_sys_b) begin
            pin_meta <= 3'h4;
            pin_sync <= 3'h4;
            sclk_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else if (clk_en) begin
            pin_meta <= {spi_cs_b, spi_sclk, spi_mosi};
            pin_sync <= pin_meta;
            sclk_prev <= pin_sync[1];
            cs_prev <= pin_sync[2];
        end
    end

    wire cs_low = ~pin_sync[2];
    wire mosi_s = pin_sync[0];
    wire sclk_rise = pin_sync[1] & ~sclk_prev & cs_low;
    wire sclk_fall = ~pin_sync[1] & sclk_prev & cs_low;
    wire cs_rise = pin_sync[2] & ~cs_prev;
    wire cs_fall = ~pin_sync[2] & cs_prev;

    // frame decode
    wire long_addr = (opcode == `FESP_OP_BLK64_ERASE_A4) || addr4_mode;
    wire [11:0] addr_bits = long_addr ? `FESP_ADDR4_BITS : `FESP_ADDR3_BITS;
    wire [11:0] addr_end = `FESP_OPC_BITS + addr_bits;
    wire [11:0] id_start = `FESP_OPC_BITS + `FESP_ID_GAP_BITS;
    wire has_opc = bit_cnt >= `FESP_OPC_BITS;
    wire exact8 = bit_cnt == `FESP_OPC_BITS;
    wire addr_exact = bit_cnt == addr_end;
    wire prog_len = (bit_cnt >= addr_end + `FESP_BYTE_BITS) && (bit_cnt[2:0] == 3'h0)
        && (bit_cnt != `FESP_BIT_CNT_MAX);

    wire is_sect_op = (opcode == `FESP_OP_SECT_ERASE) || (opcode == `FESP_OP_SECREG_ERASE);
    wire is_blk_op = (opcode == `FESP_OP_BLK32_ERASE) || (opcode == `FESP_OP_BLK64_ERASE)
        || (opcode == `FESP_OP_BLK64_ERASE_A4);
    wire is_chip_op = (opcode == `FESP_OP_CHIP_ERASE_A) || (opcode == `FESP_OP_CHIP_ERASE_B);
    wire is_prog_op = (opcode == `FESP_OP_PROG) || (opcode == `FESP_OP_QPROG)
        || (opcode == `FESP_OP_SECPROG);
    wire is_erase_op = is_sect_op | is_blk_op | is_chip_op;

    wire normal = pstate == PS_AWAKE;
    wire frame_ok = cs_rise && normal && has_opc;

    // any protected region at all; complement with all block bits set frees the array
    wire [3:0] bp = {block_protect_bit3, block_protect_bit2, block_protect_bit1,
        block_protect_bit0};
    wire any_protected = lock_any | (protect_complement ? (bp != 4'hF) : (bp != 4'h0));

    // suspend interlocks
    wire erase_locked = paused_flag && (main_cls != CLS_PROG);
    wire prog_locked = paused_flag && (main_cls == CLS_PROG);
    wire wrsr_locked = paused_flag && (opcode == `FESP_OP_WRSR);
    wire blocked = (is_erase_op && erase_locked) || (is_prog_op && prog_locked);

    // chip erase must end exactly after the opcode, erase ops after the address, program ops on a whole data byte past it
    wire well_formed = is_chip_op ? exact8 : (is_prog_op ? prog_len : addr_exact);
    wire want_op = frame_ok && (is_erase_op || is_prog_op) && well_formed;
    wire op_ok = want_op && write_enable_latch && !busy && !blocked
        && !(is_chip_op && any_protected);
    // while paused a second operation may run on the side timer, at any address, even inside the held block
    wire start_main = op_ok && !paused_flag;
    wire start_side = op_ok && paused_flag;

    wire pause_cmd = frame_ok && exact8 && (opcode == `FESP_OP_PAUSE);
    wire pause_ok = pause_cmd && !paused_flag && busy && main_run && !main_done
        && (main_cls != CLS_CHIP);
    wire resume_cmd = frame_ok && exact8 && (opcode == `FESP_OP_RESUME);
    wire resume_ok = resume_cmd && paused_flag && !busy;
    wire wren_ok = frame_ok && exact8 && (opcode == `FESP_OP_WREN);
    wire wrdi_ok = frame_ok && exact8 && (opcode == `FESP_OP_WRDI);
    wire sleep_ok = frame_ok && exact8 && (opcode == `FESP_OP_SLEEP) && !busy;
    wire wake_cmd = cs_rise && has_opc && (opcode == `FESP_OP_WAKE);
    wire wake_id = bit_cnt >= id_start;
    wire wake_ok = wake_cmd && !busy && (pstate == PS_ASLEEP) && (exact8 || wake_id);
    wire refuse = (want_op && !op_ok) || (frame_ok && wrsr_locked)
        || (pause_cmd && !pause_ok) || (resume_cmd && !resume_ok) || (wake_cmd && busy);

    // readout selection; in sleep only the wake/id read answers
    wire rd_sr1 = normal && has_opc && (opcode == `FESP_OP_RDSR1);
    wire rd_sr2 = normal && has_opc && (opcode == `FESP_OP_RDSR2);
    wire rd_id = (opcode == `FESP_OP_WAKE) && wake_id && !busy
        && (normal || pstate == PS_ASLEEP);
    wire rd_mf = normal && (opcode == `FESP_OP_MFID) && wake_id;
    wire rd_on = rd_sr1 | rd_sr2 | rd_id | rd_mf;

    reg [7:0] out_byte;

    // byte being streamed
    always @* begin
        out_byte = 8'h00;
        if (rd_sr1) begin
            out_byte[`FESP_SR1_BUSY_POS] = busy;
            out_byte[`FESP_SR1_WREN_POS] = write_enable_latch;
        end else if (rd_sr2) begin
            out_byte[`FESP_SR2_PAUSED_POS] = paused_flag;
        end else if (rd_id) begin
            out_byte = PART_CODE;
        end else if (rd_mf) begin
            out_byte = out_idx[3] ? PART_CODE : MAKER_CODE;
        end
    end

    // run length of the requested operation
    reg [31:0] run_cyc;
    always @* begin
        run_cyc = PROG_CYC;
        if (is_chip_op) begin
            run_cyc = WHOLE_ERASE_CYC;
        end else if (is_blk_op) begin
            run_cyc = BLOCK_ERASE_CYC;
        end else if (is_sect_op) begin
            run_cyc = SECTOR_ERASE_CYC;
        end
    end

    // sleep entry and both wake times share one counter, they never overlap
    wire [31:0] pwr_cyc = sleep_ok ? `FESP_SLEEP_ENTRY_CYC
        : (wake_id ? `FESP_WAKE_ID_CYC : `FESP_WAKE_CYC);

    // shift in opcode then address, msb first on rising clock edges
    always @(posedge clock or negedge rst_sys_b) begin
        if (!rst_sys_b) begin
            bit_cnt <= 12'h000;
            opcode <= 8'h00;
            addr <= 32'h00000000;
        end else if (clk_en) begin
            if (cs_fall) begin
                bit_cnt <= 12'h000;
                opcode <= 8'h00;
                addr <= 32'h00000000;
            end else if (sclk_rise) begin
                if (bit_cnt != `FESP_BIT_CNT_MAX) begin
                    bit_cnt <= bit_cnt + 12'h001;
                end
                if (bit_cnt < `FESP_OPC_BITS) begin
                    opcode <= {opcode[6:0], mosi_s};
                end else if (bit_cnt < addr_end) begin
                    addr <= {addr[30:0], mosi_s};
                end
            end
        end
    end

    // readout on falling edges; the pin is released once the synchronised select is seen high
    always @(posedge clock or negedge rst_sys_b) begin
        if (!rst_sys_b) begin
            spi_miso <= 1'b0;
            spi_miso_oe_b <= `FESP_RST_OE_B;
            out_idx <= 4'h0;
        end else if (clk_en) begin
            if (!cs_low) begin
                spi_miso_oe_b <= 1'b1;
                out_idx <= 4'h0;
            end else if (sclk_fall && rd_on) begin
                spi_miso <= out_byte[3'h7 - out_idx[2:0]];
                spi_miso_oe_b <= 1'b0;
                out_idx <= out_idx + 4'h1;
            end
        end
    end

    // operation timers: main work, side work during a pause, pause latency, power
    fesp_timer #(.W(32)) u_main (
        .clock(clock),
        .rst_sys_b(rst_sys_b),
        .clk_en(clk_en),
        .load(start_main),
        .load_val(run_cyc),
        .hold(paused_flag),
        .running(main_run),
        .done(main_done)
    );

    fesp_timer #(.W(32)) u_side (
        .clock(clock),
        .rst_sys_b(rst_sys_b),
        .clk_en(clk_en),
        .load(start_side),
        .load_val(run_cyc),
        .hold(1'b0),
        .running(),
        .done(side_done)
    );

    fesp_timer #(.W(32)) u_halt (
        .clock(clock),
        .rst_sys_b(rst_sys_b),
        .clk_en(clk_en),
        .load(pause_ok),
        .load_val(`FESP_PAUSE_CYC),
        .hold(1'b0),
        .running(),
        .done(halt_done)
    );

    fesp_timer #(.W(32)) u_pwr (
        .clock(clock),
        .rst_sys_b(rst_sys_b),
        .clk_en(clk_en),
        .load(sleep_ok | wake_ok),
        .load_val(pwr_cyc),
        .hold(1'b0),
        .running(),
        .done(pwr_done)
    );

    // status flags; a reset stands for power loss and drops any pause
    always @(posedge clock or negedge rst_sys_b) begin
        if (!rst_sys_b) begin
            busy <= `FESP_RST_FLAG;
            write_enable_latch <= `FESP_RST_FLAG;
            paused_flag <= `FESP_RST_FLAG;
            main_cls <= CLS_PROG;
        end else if (clk_en) begin
            if (start_main || start_side || resume_ok) begin
                busy <= 1'b1;
            end else if (main_done || side_done || halt_done) begin
                busy <= 1'b0;
            end
            // a write enable landing on a completion cycle still wins
            if (wren_ok) begin
                write_enable_latch <= 1'b1;
            end else if (wrdi_ok || main_done || side_done) begin
                write_enable_latch <= 1'b0;
            end
            if (pause_ok) begin
                paused_flag <= 1'b1;
            end else if (resume_ok) begin
                paused_flag <= 1'b0;
            end
            if (start_main) begin
                main_cls <= is_chip_op ? CLS_CHIP : (is_prog_op ? CLS_PROG : CLS_ERASE);
            end
        end
    end

    // operation strobes to the array
    always @(posedge clock or negedge rst_sys_b) begin
        if (!rst_sys_b) begin
            op_start <= 1'b0;
            op_code <= 8'h00;
            op_addr <= 32'h00000000;
            array_fill_ones <= 1'b0;
            cmd_refused <= 1'b0;
        end else if (clk_en) begin
            op_start <= op_ok;
            cmd_refused <= refuse;
            array_fill_ones <= main_done && (main_cls == CLS_CHIP);
            if (op_ok) begin
                op_code <= opcode;
                op_addr <= addr;
            end
        end
    end

    // power state; nothing but the wake opcode is heard until awake again
    always @(posedge clock or negedge rst_sys_b) begin
        if (!rst_sys_b) begin
            pstate <= PS_AWAKE;
            power_down <= `FESP_RST_FLAG;
        end else if (clk_en) begin
            case (pstate)
                PS_AWAKE: begin
                    if (sleep_ok) begin
                        pstate <= PS_ENTERING;
                    end
                end
                PS_ENTERING: begin
                    if (pwr_done) begin
                        pstate <= PS_ASLEEP;
                        power_down <= 1'b1;
                    end
                end
                PS_ASLEEP: begin
                    if (wake_ok) begin
                        pstate <= PS_WAKING;
                    end
                end
                PS_WAKING: begin
                    if (pwr_done) begin
                        pstate <= PS_AWAKE;
                        power_down <= 1'b0;
                    end
                end
                default: begin
                    pstate <= PS_AWAKE;
                end
            endcase
        end
    end

endmodule // fesp_seq

`default_nettype wire

// ===== fesp_regs.vh
`ifndef FESP_REGS_VH
`define FESP_REGS_VH

// instruction codes
`define FESP_OP_WREN 8'h06
`define FESP_OP_WRDI 8'h04
`define FESP_OP_RDSR1 8'h05
`define FESP_OP_RDSR2 8'h35
`define FESP_OP_WRSR 8'h01
`define FESP_OP_PROG 8'h02
`define FESP_OP_QPROG 8'h32
`define FESP_OP_SECPROG 8'h42
`define FESP_OP_SECT_ERASE 8'h20
`define FESP_OP_BLK32_ERASE 8'h52
`define FESP_OP_BLK64_ERASE 8'hD8
`define FESP_OP_BLK64_ERASE_A4 8'hDC
`define FESP_OP_CHIP_ERASE_A 8'hC7
`define FESP_OP_CHIP_ERASE_B 8'h60
`define FESP_OP_SECREG_ERASE 8'h44
`define FESP_OP_PAUSE 8'h75
`define FESP_OP_RESUME 8'h7A
`define FESP_OP_SLEEP 8'hB9
`define FESP_OP_WAKE 8'hAB
`define FESP_OP_MFID 8'h90

// status byte field positions
`define FESP_SR1_BUSY_POS 0
`define FESP_SR1_WREN_POS 1
`define FESP_SR2_PAUSED_POS 7

// reset values
`define FESP_RST_FLAG 1'b0
`define FESP_RST_OE_B 1'b1

// frame lengths in serial clock edges
`define FESP_OPC_BITS 12'd8
`define FESP_BYTE_BITS 12'd8
`define FESP_ADDR3_BITS 12'd24
`define FESP_ADDR4_BITS 12'd32
`define FESP_ID_GAP_BITS 12'd24
`define FESP_BIT_CNT_MAX 12'hFFF

// clock rate and times
`define FESP_CLK_MHZ 40
`define FESP_T_WHOLE_ERASE_US 100000
`define FESP_T_BLOCK_ERASE_US 10000
`define FESP_T_SECTOR_ERASE_US 2000
`define FESP_T_PROG_US 500
`define FESP_T_PAUSE_NS 20000
`define FESP_T_SLEEP_ENTRY_NS 3000
`define FESP_T_WAKE_NS 3000
`define FESP_T_WAKE_ID_NS 1800

// cycle counts: longest times round down, least times round up
`define FESP_WHOLE_ERASE_CYC (`FESP_T_WHOLE_ERASE_US * `FESP_CLK_MHZ)
`define FESP_BLOCK_ERASE_CYC (`FESP_T_BLOCK_ERASE_US * `FESP_CLK_MHZ)
`define FESP_SECTOR_ERASE_CYC (`FESP_T_SECTOR_ERASE_US * `FESP_CLK_MHZ)
`define FESP_PROG_CYC (`FESP_T_PROG_US * `FESP_CLK_MHZ)
`define FESP_PAUSE_CYC ((`FESP_T_PAUSE_NS * `FESP_CLK_MHZ) / 1000)
`define FESP_SLEEP_ENTRY_CYC ((`FESP_T_SLEEP_ENTRY_NS * `FESP_CLK_MHZ) / 1000)
`define FESP_WAKE_CYC ((`FESP_T_WAKE_NS * `FESP_CLK_MHZ + 999) / 1000)
`define FESP_WAKE_ID_CYC ((`FESP_T_WAKE_ID_NS * `FESP_CLK_MHZ + 999) / 1000)

`endif

// ===== fesp_timer.v
`timescale 1ns/1ps
`default_nettype none

module fesp_timer #(
    parameter W = 32
) (
    // clock and reset
    input wire clock,
    input wire rst_sys_b,
    input wire clk_en,
    // control
    input wire load,
    input wire [W-1:0] load_val,
    input wire hold,
    // status
    output reg running,
    output reg done
);

    reg [W-1:0] cnt;

    // down counter; a zero load still takes one cycle so done is never lost
    always @(posedge clock or negedge rst_sys_b) begin
        if (!rst_sys_b) begin
            cnt <= {W{1'b0}};
            running <= 1'b0;
            done <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            if (load) begin
                cnt <= (load_val == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : load_val;
                running <= 1'b1;
            end else if (running && !hold) begin
                if (cnt <= {{(W-1){1'b0}}, 1'b1}) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // fesp_timer

`default_nettype wire

// ===== fesp_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none

module fesp_seq_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // pins and configuration
    input wire logic spi_cs_b,
    input wire logic spi_miso_oe_b,
    input wire logic lock_any,
    // status and events
    input wire logic busy,
    input wire logic write_enable_latch,
    input wire logic paused_flag,
    input wire logic power_down,
    input wire logic op_start,
    input wire logic [7:0] op_code,
    input wire logic array_fill_ones,
    input wire logic cmd_refused
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // both whole-array opcodes behave alike
    wire logic whole_op = (op_code == 8'hC7) || (op_code == 8'h60);

    start_idle_a: assert property (op_start |-> busy && write_enable_latch && !$past(busy))
        else $error("start without latch or while busy");
    fill_end_a: assert property (array_fill_ones |-> !busy && !write_enable_latch && whole_op)
        else $error("fill without finished whole erase");
    busy_end_a: assert property ($fell(busy) && !paused_flag |-> !write_enable_latch)
        else $error("latch kept after operation end");
    chip_lock_a: assert property (op_start && whole_op |-> !lock_any)
        else $error("whole erase started while locked");
    pause_drop_a: assert property ($rose(paused_flag) |-> busy ##[1:810] !busy)
        else $error("busy not dropped after pause");
    pause_chip_a: assert property (paused_flag |-> !whole_op)
        else $error("whole erase paused");
    resume_busy_a: assert property ($fell(paused_flag) |-> !$past(busy) ##[0:8] busy)
        else $error("resume without busy return");
    sleep_deaf_a: assert property (power_down && $past(power_down) |-> !op_start && !cmd_refused)
        else $error("request heard while asleep");
    frame_end_a: assert property (spi_cs_b [*6] |-> spi_miso_oe_b)
        else $error("data out driven after deselect");

    // main scenarios reached
    cover property ($rose(paused_flag));
    cover property (array_fill_ones);
    cover property ($fell(power_down));
endmodule // fesp_seq_checker

bind fesp_seq fesp_seq_checker chk (
    .clock(clock), .rst_b(rst_b), .spi_cs_b(spi_cs_b), .spi_miso_oe_b(spi_miso_oe_b),
    .lock_any(lock_any), .busy(busy), .write_enable_latch(write_enable_latch),
    .paused_flag(paused_flag), .power_down(power_down), .op_start(op_start),
    .op_code(op_code), .array_fill_ones(array_fill_ones), .cmd_refused(cmd_refused)
);

`default_nettype wire

// ===== fesp_host.sv
`timescale 1ns/1ps
`default_nettype none

module fesp_host (
    // clock
    input wire logic clock,
    // serial pins
    output logic spi_cs_b,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso
);
    // idle bus: deselected, clock parked low
    initial begin
        spi_cs_b = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end

    // n bits out msb first, then nr bits captured; 200 ns per bit
    task automatic xfer(input logic [63:0] tx, input int n, input int nr,
            output logic [31:0] rx);
        rx = 32'h0;
        @(negedge clock);
        spi_cs_b = 1'b0;
        for (int i = 0; i < n + nr; i++) begin
            spi_mosi = (i < n) ? tx[63 - i] : ~spi_mosi;
            repeat (4) @(negedge clock);
            spi_sclk = 1'b1;
            repeat (4) @(negedge clock);
            // sampled late in the high phase, data settles after the fall
            if (i >= n) rx = {rx[30:0], spi_miso};
            spi_sclk = 1'b0;
        end
        repeat (2) @(negedge clock);
        spi_cs_b = 1'b1;
        spi_mosi = ~spi_mosi; // released line shows no stale bit
    endtask
endmodule // fesp_host

`default_nettype wire

// ===== fesp_seq_tb.sv
`timescale 1ns/1ps
`default_nettype none

module fesp_seq_tb;
    typedef struct {
        logic [63:0] tx;
        int n;
        logic wren;
        logic [5:0] pr;
        logic go;
        logic fill;
        logic [31:0] addr;
    } fesp_row_t;
    logic clock, rst_b, addr4_mode;
    logic [5:0] prot;
    logic [31:0] rx;
    wire logic spi_cs_b, spi_sclk, spi_mosi, spi_miso, spi_miso_oe_b;
    wire logic busy, write_enable_latch, paused_flag, power_down, op_start;
    wire logic array_fill_ones, cmd_refused;
    wire logic [7:0] op_code;
    wire logic [31:0] op_addr;
    int fail_count = 0, total_checks = 0, n_start = 0, n_ref = 0, n_fill = 0, s0, f0;
    // protection {lock, complement, bp3..bp0}; boundary cases of the complement
    fesp_row_t rows [10] = '{
        '{{8'hC7, 56'h0}, 8, 1, 6'h00, 1, 1, 32'h0},
        '{{8'h60, 56'h0}, 8, 1, 6'h1F, 1, 1, 32'h0},
        '{{8'hDC, 32'h12345678, 24'h0}, 40, 1, 6'h00, 1, 0, 32'h12345678},
        '{{8'hD8, 24'h0ABCDE, 32'h0}, 32, 1, 6'h00, 1, 0, 32'h000ABCDE},
        '{{8'h20, 24'h000123, 32'h0}, 32, 1, 6'h00, 1, 0, 32'h00000123},
        '{{8'hC7, 56'h0}, 9, 1, 6'h00, 0, 0, 32'h0},
        '{{8'hC7, 56'h0}, 8, 0, 6'h00, 0, 0, 32'h0},
        '{{8'h60, 56'h0}, 8, 1, 6'h01, 0, 0, 32'h0},
        '{{8'hC7, 56'h0}, 8, 1, 6'h10, 0, 0, 32'h0},
        '{{8'hC7, 56'h0}, 8, 1, 6'h20, 0, 0, 32'h0}
    };

    fesp_seq #(.WHOLE_ERASE_CYC(400), .BLOCK_ERASE_CYC(3000), .SECTOR_ERASE_CYC(50),
            .PROG_CYC(50)) dut (
        .clock(clock), .rst_b(rst_b), .clk_en(1'b1), .spi_cs_b(spi_cs_b),
        .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe_b(spi_miso_oe_b), .addr4_mode(addr4_mode),
        .protect_complement(prot[4]), .block_protect_bit3(prot[3]),
        .block_protect_bit2(prot[2]), .block_protect_bit1(prot[1]),
        .block_protect_bit0(prot[0]), .lock_any(prot[5]), .busy(busy),
        .write_enable_latch(write_enable_latch), .paused_flag(paused_flag),
        .power_down(power_down), .op_start(op_start), .op_code(op_code),
        .op_addr(op_addr), .array_fill_ones(array_fill_ones), .cmd_refused(cmd_refused)
    );
    fesp_host host (.clock(clock), .spi_cs_b(spi_cs_b), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso));

    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // one-cycle pulses are counted mid-cycle
    always @(negedge clock) begin
        n_start += (op_start === 1'b1);
        n_ref += (cmd_refused === 1'b1);
        n_fill += (array_fill_ones === 1'b1);
    end

    task automatic conclude();
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic send(input logic [7:0] b, input int n);
        host.xfer({b, 56'h0}, n, 0, rx);
        repeat (8) @(negedge clock);
    endtask

    task automatic refuse(input logic [7:0] b, input int n);
        int r0;
        r0 = n_ref;
        send(b, n);
        chk("refused", 1, 32'(n_ref - r0));
    endtask

    // bounded wait on the busy level
    task automatic wait_busy(input logic v, input int lim);
        for (int k = 0; k < lim && busy !== v; k++) @(negedge clock);
        @(negedge clock);
        chk("busy", v, busy);
    endtask

    // pins stay synchronised for a few edges after release
    task automatic reset_dut();
        rst_b = 1'b0;
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        repeat (6) @(negedge clock);
        chk("flags", 5'h01, {busy, write_enable_latch, paused_flag, power_down, spi_miso_oe_b});
    endtask

    // watchdog well beyond the expected run
    initial begin
        repeat (100000) @(negedge clock);
        fail_count++;
        conclude();
    end

    initial begin
        rst_b = 1'b0;
        addr4_mode = 1'b0;
        prot = 6'h00;
        reset_dut();
        foreach (rows[i]) begin
            prot = rows[i].pr;
            send(rows[i].wren ? 8'h06 : 8'h04, 8);
            s0 = n_start;
            f0 = n_fill;
            host.xfer(rows[i].tx, rows[i].n, 0, rx);
            repeat (8) @(negedge clock);
            chk("start", rows[i].go, 32'(n_start - s0));
            if (rows[i].go) begin
                chk("code", rows[i].tx[63:56], op_code);
                if (rows[i].n > 8) chk("addr", rows[i].addr, op_addr);
                wait_busy(1'b0, 4000);
                chk("wel", 0, write_enable_latch);
            end
            chk("fill", rows[i].fill, 32'(n_fill - f0));
        end
        prot = 6'h00;
        // block erase paused, side erase, status write and pause refused, a side program run, then resumed
        send(8'h06, 8);
        send(8'hD8, 32);
        host.xfer({8'h05, 56'h0}, 8, 8, rx);
        chk("status", 2'b11, rx[1:0]);
        // leave select high long enough to be seen between frames
        repeat (8) @(negedge clock);
        refuse(8'hAB, 8);
        send(8'h75, 8);
        chk("paused", 2'b11, {paused_flag, busy});
        wait_busy(1'b0, 900);
        // second status byte still readable and shows the pause
        host.xfer({8'h35, 56'h0}, 8, 8, rx);
        chk("status2", 1, rx[7]);
        repeat (8) @(negedge clock);
        refuse(8'h20, 32);
        refuse(8'h01, 16);
        refuse(8'h75, 8);
        // a program at address 0, inside the held erase's block, runs while the erase is held
        s0 = n_start;
        send(8'h02, 40);
        chk("side", 1, 32'(n_start - s0));
        wait_busy(1'b0, 100);
        send(8'h7A, 8);
        chk("resumed", 2'b01, {paused_flag, busy});
        wait_busy(1'b0, 4000);
        refuse(8'h7A, 8);
        refuse(8'h75, 8);
        // whole-array erase cannot be paused
        send(8'h06, 8);
        send(8'hC7, 8);
        refuse(8'h75, 8);
        chk("paused", 0, paused_flag);
        wait_busy(1'b0, 600);
        // power lost while paused
        send(8'h06, 8);
        send(8'hD8, 32);
        send(8'h75, 8);
        wait_busy(1'b0, 900);
        reset_dut();
        refuse(8'h7A, 8);
        chk("busy", 0, busy);
        // four-byte mode: plain block erase takes 32 address bits too
        addr4_mode = 1'b1;
        send(8'h06, 8);
        host.xfer({8'hD8, 32'hA1B2C3D4, 24'h0}, 40, 0, rx);
        repeat (8) @(negedge clock);
        chk("addr4", 32'hA1B2C3D4, op_addr);
        wait_busy(1'b0, 4000);
        addr4_mode = 1'b0;
        // sleep hears only the wake opcode
        send(8'hB9, 8);
        repeat (120) @(negedge clock);
        chk("asleep", 1, power_down);
        send(8'h06, 8);
        chk("wel", 0, write_enable_latch);
        send(8'hAB, 8);
        chk("waking", 1, power_down);
        repeat (120) @(negedge clock);
        chk("awake", 0, power_down);
        host.xfer({8'hAB, 56'h0}, 32, 16, rx);
        chk("id", 16'h3C3C, rx[15:0]);
        repeat (80) @(negedge clock);
        host.xfer({8'h90, 56'h0}, 32, 16, rx);
        chk("maker", 16'hA53C, rx[15:0]);
        conclude();
    end
endmodule // fesp_seq_tb

`default_nettype wire
